/* wsl_pkg.sv */
// holds constants, register map and carrier types of the write-once security latch
// assumes a 32-bit apb master and a 200 MHz sys_clk with synchronous srst
//
// What this block does
// R1: latch keeps one 32-bit word of four bytes, compared against the key pattern
// R2: lock output is 1 when 28 or more of 32 bits match the key
// R3: sampled lock closes every test, programming and debug port
// R4: sampled lock refuses every erase or change of the latch word
// R5: lock is taken only at reset; later latch changes leave access as is
// R6: host loads key, commits it to nonvolatile cells, then resets the part
// R7: key write accepted only while no flash protection is set
// R8: after key write full access stays until the next reset
// R9: latch word can be read out through the swd port
// R10: raised protection is cleared only by or after a full device erase; here por clears it as well
// R11: block erase, program and verify run only when block security permits; here verify runs on a protected block too
// R12: match count is bitwise equality then population count against threshold
`default_nettype none

package wsl_pkg;

	localparam int ADDR_W = 8;

	localparam logic [ADDR_W-1:0] OFF_KEY_STAGE = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_CMD = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_BLK_SEC = 8'h0C;
	localparam logic [ADDR_W-1:0] OFF_BLK_OP = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_NV_WORD = 8'h14;

	localparam int CMD_COMMIT_BIT = 0;
	localparam int CMD_ERASE_ALL_BIT = 1;

	localparam int BLK_OP_IDX_LSB = 0;
	localparam int BLK_OP_CODE_LSB = 8;

	localparam logic [1:0] OP_ERASE = 2'h0;
	localparam logic [1:0] OP_PROGRAM = 2'h1;
	localparam logic [1:0] OP_VERIFY = 2'h2;

	localparam int KEY_W = 32;
	localparam logic [5:0] MATCH_THRESHOLD = 6'h1C;
	localparam logic [31:0] KEY_STAGE_RESET = 32'h0000_0000;

	typedef struct packed {
		logic op_granted;
		logic op_refused;
		logic key_refused;
		logic erased;
		logic prot_set;
		logic match_live;
		logic lock_sampled;
	} wsl_status_s;

	localparam int STATUS_W = 7;
	localparam int ST_OP_GRANTED_BIT = 6;
	localparam int ST_OP_REFUSED_BIT = 5;
	localparam int ST_KEY_REFUSED_BIT = 4;

	typedef struct packed {
		logic valid;
		logic [7:0] block;
		logic [1:0] code;
	} wsl_flash_op_s;

endpackage

`default_nettype wire

/* wsl_top.sv */
// holds the security latch, its lock sampling, port gating and flash guard
// assumes apb and the swd readback request come from logic on sys_clk
//
// Implementation choices: the APB interface to the registers and the register addresses.
`default_nettype none

module wsl_top #(
	parameter int NUM_BLOCKS = 32,
	// arbitrary neutral key value; a real part sets its own
	parameter logic [31:0] LOCK_KEY = 32'hA5C3_1E96
) (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic por,
	input wire logic [31:0] nv_power_on_value,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [wsl_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic swd_rd_req,
	output logic [31:0] swd_rd_data,
	output logic swd_rd_valid,
	output logic debug_port_en,
	output logic test_port_en,
	output logic prog_port_en,
	output logic lock_active,
	output wsl_pkg::wsl_flash_op_s flash_op,
	output logic flash_erase_all
);

	////////////////////////////////////////////////////////////////////////////
	// storage

	logic [31:0] nv_word_q;
	logic [31:0] key_stage_q;
	logic lock_q;
	logic port_en_q;
	logic erased_q;
	logic [NUM_BLOCKS-1:0] blk_sec_q;
	logic key_refused_q;
	logic op_refused_q;
	logic op_granted_q;

	////////////////////////////////////////////////////////////////////////////
	// match detector

	logic [31:0] bit_eq;
	logic [5:0] match_count;
	logic match_live;

	// a few failed cells must not drop the lock, hence a threshold and not equality
	genvar gi;
	generate
		for (gi = 0; gi < wsl_pkg::KEY_W; gi++) begin : g_eq
			assign bit_eq[gi] = ~(nv_word_q[gi] ^ LOCK_KEY[gi]); // [R12] [R1]
		end
	endgenerate

	always_comb begin
		match_count = 6'h00;
		for (int i = 0; i < wsl_pkg::KEY_W; i++) begin
			match_count = match_count + {5'h00, bit_eq[i]}; // [R12]
		end
	end

	assign match_live = (match_count >= wsl_pkg::MATCH_THRESHOLD); // [R2]

	////////////////////////////////////////////////////////////////////////////
	// apb decode

	logic access;
	logic wr_en;
	logic rd_setup;
	logic hit_key;
	logic hit_cmd;
	logic hit_status;
	logic hit_blk_sec;
	logic hit_blk_op;
	logic hit_nv;
	logic mapped;
	logic prot_set;
	logic [31:0] wdata_m;

	assign access = psel & penable;
	assign wr_en = access & pwrite;
	assign rd_setup = psel & ~penable & ~pwrite;
	assign hit_key = (paddr == wsl_pkg::OFF_KEY_STAGE);
	assign hit_cmd = (paddr == wsl_pkg::OFF_CMD);
	assign hit_status = (paddr == wsl_pkg::OFF_STATUS);
	assign hit_blk_sec = (paddr == wsl_pkg::OFF_BLK_SEC);
	assign hit_blk_op = (paddr == wsl_pkg::OFF_BLK_OP);
	assign hit_nv = (paddr == wsl_pkg::OFF_NV_WORD);
	assign mapped = hit_key | hit_cmd | hit_status | hit_blk_sec | hit_blk_op | hit_nv;
	assign prot_set = |blk_sec_q;

	genvar gb;
	generate
		for (gb = 0; gb < 4; gb++) begin : g_byte
			assign wdata_m[8*gb +: 8] = pstrb[gb] ? pwdata[8*gb +: 8] : 8'h00;
		end
	endgenerate

	assign pready = 1'b1;
	// locked part answers any write other than status clear with an error
	logic wr_refused;
	assign wr_refused = pwrite & lock_q & ~hit_status; // [R3] [R4]
	assign pslverr = access & (~mapped | wr_refused); // [R3]

	logic wr_ok;
	assign wr_ok = wr_en & ~lock_q; // [R3] [R4]

	////////////////////////////////////////////////////////////////////////////
	// key staging and commit

	logic key_wr;
	logic commit_req;
	logic erase_req;
	logic key_block;

	assign key_wr = wr_ok & hit_key;
	assign commit_req = wr_ok & hit_cmd & pwdata[wsl_pkg::CMD_COMMIT_BIT];
	assign erase_req = wr_ok & hit_cmd & pwdata[wsl_pkg::CMD_ERASE_ALL_BIT];
	assign key_block = prot_set; // [R7]

	// staging is volatile; only a commit reaches the nonvolatile word
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			key_stage_q <= wsl_pkg::KEY_STAGE_RESET;
		end else if (key_wr && !key_block) begin // [R7]
			for (int b = 0; b < 4; b++) begin
				if (pstrb[b]) begin
					key_stage_q[8*b +: 8] <= pwdata[8*b +: 8];
				end
			end
		end
	end

	// nonvolatile cells survive srst; only power-on or a commit loads them
	always_ff @(posedge sys_clk) begin
		if (por) begin
			nv_word_q <= nv_power_on_value;
		end else if (commit_req && !key_block && !lock_q) begin // [R4] [R7] [R6]
			nv_word_q <= key_stage_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// lock sampled at reset only

	// the last por or srst edge before release decides the lock
	always_ff @(posedge sys_clk) begin
		if (srst || por) begin
			lock_q <= match_live; // [R5]
			port_en_q <= ~match_live; // [R3] [R5]
		end
	end

	// commits between resets never reach the gates: only the sampled flops do [R8]
	assign lock_active = lock_q;
	assign debug_port_en = port_en_q; // [R3]
	assign test_port_en = port_en_q; // [R3]
	assign prog_port_en = port_en_q; // [R3]

	////////////////////////////////////////////////////////////////////////////
	// flash protection and full erase

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			erased_q <= 1'b0;
		end else if (erase_req) begin
			erased_q <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (por) begin
			blk_sec_q <= '0;
		end else if (erase_req) begin
			blk_sec_q <= '0; // [R10]
		end else if (wr_ok && hit_blk_sec) begin
			if (erased_q) begin
				blk_sec_q <= wdata_m[NUM_BLOCKS-1:0]; // [R10]
			end else begin
				blk_sec_q <= blk_sec_q | wdata_m[NUM_BLOCKS-1:0]; // [R10]
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			flash_erase_all <= 1'b0;
		end else begin
			flash_erase_all <= erase_req;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// block operations

	logic op_req;
	logic [7:0] op_idx;
	logic [1:0] op_code;
	logic idx_ok;
	logic blk_protected;
	logic op_permit;

	assign op_req = wr_ok & hit_blk_op;
	assign op_idx = pwdata[wsl_pkg::BLK_OP_IDX_LSB +: 8];
	assign op_code = pwdata[wsl_pkg::BLK_OP_CODE_LSB +: 2];
	assign idx_ok = ({24'h00_0000, op_idx} < 32'(NUM_BLOCKS));

	always_comb begin
		blk_protected = 1'b1;
		for (int k = 0; k < NUM_BLOCKS; k++) begin
			if (op_idx == 8'(k)) begin
				blk_protected = blk_sec_q[k];
			end
		end
	end

	// verify only reads, so a protected block still allows it
	always_comb begin
		case (op_code)
			wsl_pkg::OP_ERASE: op_permit = idx_ok & ~blk_protected; // [R11]
			wsl_pkg::OP_PROGRAM: op_permit = idx_ok & ~blk_protected; // [R11]
			wsl_pkg::OP_VERIFY: op_permit = idx_ok; // [R11]
			default: op_permit = 1'b0;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			flash_op <= '0;
		end else begin
			flash_op.valid <= op_req & op_permit; // [R11]
			if (op_req && op_permit) begin
				flash_op.block <= op_idx;
				flash_op.code <= op_code;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// sticky status flags, set wins over write-one-to-clear

	logic st_clr;
	assign st_clr = wr_en & hit_status;

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			key_refused_q <= 1'b0;
		end else if ((key_wr || commit_req) && key_block) begin
			key_refused_q <= 1'b1; // [R7]
		end else if (st_clr && wdata_m[wsl_pkg::ST_KEY_REFUSED_BIT]) begin
			key_refused_q <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			op_refused_q <= 1'b0;
		end else if (op_req && !op_permit) begin
			op_refused_q <= 1'b1; // [R11]
		end else if (st_clr && wdata_m[wsl_pkg::ST_OP_REFUSED_BIT]) begin
			op_refused_q <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			op_granted_q <= 1'b0;
		end else if (op_req && op_permit) begin
			op_granted_q <= 1'b1;
		end else if (st_clr && wdata_m[wsl_pkg::ST_OP_GRANTED_BIT]) begin
			op_granted_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// read mux

	wsl_pkg::wsl_status_s status;
	logic [31:0] rd_mux;
	logic [31:0] prdata_q;

	always_comb begin
		status.op_granted = op_granted_q;
		status.op_refused = op_refused_q;
		status.key_refused = key_refused_q;
		status.erased = erased_q;
		status.prot_set = prot_set;
		status.match_live = match_live;
		status.lock_sampled = lock_q;
	end

	always_comb begin
		rd_mux = 32'h0000_0000;
		if (hit_status) begin
			rd_mux = {{(32 - wsl_pkg::STATUS_W){1'b0}}, status};
		end else if (!lock_q) begin // [R3]
			if (hit_key) begin
				rd_mux = key_stage_q;
			end else if (hit_blk_sec) begin
				rd_mux[NUM_BLOCKS-1:0] = blk_sec_q;
			end else if (hit_nv) begin
				rd_mux = nv_word_q;
			end
		end
	end

	// read word is taken in the setup cycle, so the access phase sees a flop
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			prdata_q <= 32'h0000_0000;
		end else if (rd_setup) begin
			prdata_q <= rd_mux;
		end else begin
			prdata_q <= 32'h0000_0000;
		end
	end

	assign prdata = prdata_q;

	////////////////////////////////////////////////////////////////////////////
	// swd readback, open even on a locked part

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			swd_rd_valid <= 1'b0;
			swd_rd_data <= 32'h0000_0000;
		end else begin
			swd_rd_valid <= swd_rd_req; // [R9]
			if (swd_rd_req) begin
				swd_rd_data <= nv_word_q; // [R9]
			end
		end
	end

endmodule

`default_nettype wire

/* wsl_swd_host.sv */
// swd host stand-in: asks for the latch word and keeps the answer
// assumes the device answers on sys_clk
`default_nettype none
module wsl_swd_host (
	input wire logic sys_clk,
	input wire logic go,
	output logic swd_rd_req,
	input wire logic swd_rd_valid,
	input wire logic [31:0] swd_rd_data,
	output logic [31:0] word_q
);
	timeunit 1ns;
	timeprecision 1ps;
	always @(posedge sys_clk) begin
		swd_rd_req <= go;
		if (swd_rd_valid) begin
			word_q <= swd_rd_data;
		end
	end
endmodule
`default_nettype wire

/* wsl_props.sv */
// checker on the ports of the write-once security latch
// assumes one clock and synchronous srst
`default_nettype none
module wsl_props (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic por,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [wsl_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	input wire logic swd_rd_req,
	input wire logic swd_rd_valid,
	input wire logic debug_port_en,
	input wire logic lock_active,
	input wire wsl_pkg::wsl_flash_op_s flash_op,
	input wire logic flash_erase_all
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (srst);
	sequence s_acc;
		psel && penable;
	endsequence
	sequence s_lk;
		s_acc ##0 (lock_active && paddr != wsl_pkg::OFF_STATUS);
	endsequence
	sequence s_era;
		s_acc ##0 (pwrite && paddr == wsl_pkg::OFF_CMD &&
			pwdata[wsl_pkg::CMD_ERASE_ALL_BIT] && !lock_active);
	endsequence
	a_port_gate: assert property (debug_port_en == !lock_active)
		else $error("debug port open while locked");
	a_lock_held: assert property (!$past(srst) && !$past(por) |-> $stable(lock_active))
		else $error("lock changed between resets");
	a_locked_wr: assert property (s_lk ##0 pwrite |-> pslverr)
		else $error("locked write not refused");
	a_locked_rd: assert property (s_lk ##0 !pwrite |-> prdata == 32'h0)
		else $error("locked read gave data");
	a_swd_ans: assert property (swd_rd_req |=> swd_rd_valid)
		else $error("swd answer missing");
	a_swd_quiet: assert property (!swd_rd_req |=> !swd_rd_valid)
		else $error("swd valid unasked");
	a_erase_go: assert property (s_era |=> flash_erase_all)
		else $error("erase all missing");
	a_lock_still: assert property (lock_active |-> !flash_op.valid && !flash_erase_all)
		else $error("flash action while locked");
endmodule
bind wsl_top wsl_props i_wsl_props (.sys_clk(sys_clk), .srst(srst), .por(por), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pslverr(pslverr), .swd_rd_req(swd_rd_req), .swd_rd_valid(swd_rd_valid),
	.debug_port_en(debug_port_en), .lock_active(lock_active), .flash_op(flash_op),
	.flash_erase_all(flash_erase_all));
`default_nettype wire

/* wsl_top_tb.sv */
// self-checking bench of the write-once security latch
// assumes package, design, host model and checker compiled first
`default_nettype none
module wsl_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] KEY = 32'h3C5A_0FF1; // arbitrary key value
	logic sys_clk = 1'b0, srst = 1'b1, por = 1'b1, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, go = 1'b0, err, pready, pslverr, swd_rd_req, swd_rd_valid;
	logic debug_port_en, test_port_en, prog_port_en, lock_active, flash_erase_all;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, nvp = 32'h0, rd, w, prdata, swd_rd_data, word_q;
	wsl_pkg::wsl_flash_op_s flash_op;
	int n_errors = 0, total_checks = 0, cyc = 0;
	wire [3:0] pv = {lock_active, debug_port_en, test_port_en, prog_port_en};
	wsl_top #(.LOCK_KEY(KEY)) i_wsl_top (.sys_clk(sys_clk), .srst(srst), .por(por),
		.nv_power_on_value(nvp), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .swd_rd_req(swd_rd_req), .swd_rd_data(swd_rd_data),
		.swd_rd_valid(swd_rd_valid), .debug_port_en(debug_port_en),
		.test_port_en(test_port_en), .prog_port_en(prog_port_en),
		.lock_active(lock_active), .flash_op(flash_op), .flash_erase_all(flash_erase_all));
	wsl_swd_host i_wsl_swd_host (.sys_clk(sys_clk), .go(go), .swd_rd_req(swd_rd_req),
		.swd_rd_valid(swd_rd_valid), .swd_rd_data(swd_rd_data), .word_q(word_q));
	initial begin
		forever #2.5 sys_clk = ~sys_clk;
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			n_errors++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic do_reset(input logic p);
		@(posedge sys_clk);
		srst <= 1'b1;
		por <= p;
		repeat (4) @(posedge sys_clk);
		srst <= 1'b0;
		por <= 1'b0;
		#1;
	endtask
	task automatic t_swd(input logic [31:0] e);
		@(posedge sys_clk);
		go <= 1'b1;
		@(posedge sys_clk);
		go <= 1'b0;
		repeat (2) @(posedge sys_clk);
		#1 chk("swd_word", e, word_q);
	endtask
	task automatic t_match;
		for (int k = 0; k < 6; k++) begin
			w = KEY ^ ((32'h1 << k) - 32'h1);
			apb(1'b1, wsl_pkg::OFF_KEY_STAGE, w);
			apb(1'b1, wsl_pkg::OFF_CMD, 32'h1);
			apb(1'b0, wsl_pkg::OFF_STATUS, 32'h0);
			chk("match", 32'(k < 5), 32'(rd[1]));
			apb(1'b0, wsl_pkg::OFF_NV_WORD, 32'h0);
			chk("nv_word", w, rd);
		end
		t_swd(w);
	endtask
	task automatic t_guard;
		apb(1'b1, wsl_pkg::OFF_BLK_SEC, 32'h1);
		apb(1'b1, wsl_pkg::OFF_KEY_STAGE, KEY);
		apb(1'b1, wsl_pkg::OFF_CMD, 32'h1);
		apb(1'b0, wsl_pkg::OFF_STATUS, 32'h0);
		chk("key_refused", 32'h1, 32'(rd[4]));
		apb(1'b0, wsl_pkg::OFF_NV_WORD, 32'h0);
		chk("nv_kept", w, rd);
		apb(1'b1, wsl_pkg::OFF_BLK_OP, 32'h0);
		#1 chk("op_refused", 32'h0, 32'(flash_op.valid));
		for (int c = 0; c < 3; c++) begin
			apb(1'b1, wsl_pkg::OFF_BLK_OP, 32'(c << 8) | 32'h1);
			#1 chk("op_code", 32'h4 | 32'(c), 32'({flash_op.valid, flash_op.code}));
			chk("op_block", 32'h1, 32'(flash_op.block));
		end
		apb(1'b1, wsl_pkg::OFF_BLK_OP, 32'h200);
		#1 chk("verify_prot", 32'h6, 32'({flash_op.valid, flash_op.code}));
		apb(1'b1, wsl_pkg::OFF_BLK_OP, 32'h301);
		#1 chk("op_code3", 32'h0, 32'(flash_op.valid));
		apb(1'b1, wsl_pkg::OFF_BLK_OP, 32'h220);
		#1 chk("op_range", 32'h0, 32'(flash_op.valid));
		apb(1'b0, wsl_pkg::OFF_STATUS, 32'h0);
		chk("op_flags", 32'h3, 32'(rd[6:5]));
		apb(1'b1, wsl_pkg::OFF_STATUS, 32'h20);
		apb(1'b0, wsl_pkg::OFF_STATUS, 32'h0);
		chk("op_refused_clr", 32'h2, 32'(rd[6:5]));
		apb(1'b1, wsl_pkg::OFF_BLK_SEC, 32'h0);
		apb(1'b0, wsl_pkg::OFF_BLK_SEC, 32'h0);
		chk("prot_kept", 32'h1, rd);
		apb(1'b1, wsl_pkg::OFF_CMD, 32'h2);
		#1 chk("erase_all", 32'h1, 32'(flash_erase_all));
		apb(1'b0, wsl_pkg::OFF_BLK_SEC, 32'h0);
		chk("prot_clear", 32'h0, rd);
	endtask
	task automatic t_lock;
		apb(1'b1, wsl_pkg::OFF_KEY_STAGE, KEY);
		apb(1'b1, wsl_pkg::OFF_CMD, 32'h1);
		apb(1'b0, wsl_pkg::OFF_KEY_STAGE, 32'h0);
		chk("key_readback", KEY, rd);
		chk("open_after_key", 32'h7, 32'(pv));
		do_reset(1'b0);
		chk("ports_shut", 32'h8, 32'(pv));
		apb(1'b1, wsl_pkg::OFF_KEY_STAGE, 32'h0);
		chk("locked_write", 32'h1, 32'(err));
		apb(1'b0, wsl_pkg::OFF_NV_WORD, 32'h0);
		chk("locked_read", 32'h0, rd);
		apb(1'b1, wsl_pkg::OFF_CMD, 32'h3);
		chk("locked_cmd", 32'h1, 32'(err));
		#1 chk("locked_erase", 32'h0, 32'(flash_erase_all));
		t_swd(KEY);
		do_reset(1'b1);
		chk("unlocked", 32'h7, 32'(pv));
	endtask
	task finish_test;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			n_errors++;
			finish_test;
		end
	end
	initial begin
		do_reset(1'b1);
		chk("ports_open", 32'h7, 32'(pv));
		apb(1'b0, 8'h3C, 32'h0);
		chk("unmapped", 32'h1, 32'(err));
		t_match;
		t_guard;
		t_lock;
		finish_test;
	end
endmodule
`default_nettype wire
